//--- verilog/pif_pkg.sv
// Package for the peripheral interrupt flag block: offsets, layouts, reset values
package pif_pkg;
  // Register byte offsets on APB (word aligned)
  localparam logic [7:0] PIF_OFF_CONTROL = 8'h00;
  localparam logic [7:0] PIF_OFF_OPTION = 8'h04;
  localparam logic [7:0] PIF_OFF_ENABLES_ONE = 8'h08;
  localparam logic [7:0] PIF_OFF_ENABLES_TWO = 8'h0C;
  localparam logic [7:0] PIF_OFF_ENABLES_THREE = 8'h10;
  localparam logic [7:0] PIF_OFF_FLAGS_ONE = 8'h14;
  localparam logic [7:0] PIF_OFF_FLAGS_TWO = 8'h18;
  localparam logic [7:0] PIF_OFF_FLAGS_THREE = 8'h1C;
  localparam logic [7:0] PIF_OFF_EVT_STATUS = 8'h20;
  localparam logic [7:0] PIF_OFF_EVT_CLEAR = 8'h24;
  localparam logic [7:0] PIF_OFF_EVT_ENABLE = 8'h28;

  // Implemented bit masks of the flag/enable registers
  localparam logic [7:0] PIF_MASK_ONE = 8'hFF;
  localparam logic [7:0] PIF_MASK_TWO = 8'hFD;
  localparam logic [7:0] PIF_MASK_THREE = 8'h7A;

  // Control register bit positions
  localparam int PIF_BIT_GLOBAL_EN = 7;
  localparam int PIF_BIT_PERIPH_EN = 6;

  // Flags-two bit positions
  localparam int PIF_BIT_OSC_FAIL = 7;
  localparam int PIF_BIT_COMP_B = 6;
  localparam int PIF_BIT_COMP_A = 5;
  localparam int PIF_BIT_NVM_DONE = 4;
  localparam int PIF_BIT_BUS_COLL = 3;
  localparam int PIF_BIT_LCD = 2;
  localparam int PIF_BIT_CAPCMP_TWO = 0;
  // Flags-three bit positions
  localparam int PIF_BIT_CAPCMP_FIVE = 6;
  localparam int PIF_BIT_CAPCMP_FOUR = 5;
  localparam int PIF_BIT_CAPCMP_THREE = 4;
  localparam int PIF_BIT_TIMER_SIX = 3;
  localparam int PIF_BIT_TIMER_FOUR = 1;

  // Reset values
  localparam logic [7:0] PIF_RST_REG = 8'h00;
  localparam logic [2:0] PIF_RST_EVT = 3'h0;

  // Number of flag/enable register pairs
  localparam int PIF_NUM_BANKS = 3;

  // Event status bits: one per flag bank going pending
  localparam int PIF_EVT_W = 3;

  typedef struct packed {
    logic [7:0] one;
    logic [7:0] two;
    logic [7:0] three;
  } pif_bank_s;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } pif_apb_req_s;
endpackage

//--- verilog/pif_flag_bank.sv
// One 8-bit peripheral flag register with its enable register
`timescale 1ns/1ps
`default_nettype none
module pif_flag_bank #(
  parameter logic [7:0] MASK = 8'hFF
) (
  input wire logic I_CLK,            // Core clock
  input wire logic I_RESET_N,        // Async reset, active low
  input wire logic [7:0] i_set,      // Condition pulses from peripherals
  input wire logic i_wr_flag,        // Software write of flag register
  input wire logic i_wr_enable,      // Software write of enable register
  input wire logic [7:0] i_wdata,    // Write data
  output logic [7:0] o_flag,         // Flag register contents
  output logic [7:0] o_enable,       // Enable register contents
  output logic o_request             // Any enabled flag pending
);
  import pif_pkg::*;

  // Hardware set wins over a software write of zero in the same cycle
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      o_flag <= PIF_RST_REG;
    end else if (i_wr_flag) begin
      o_flag <= (i_wdata | i_set) & MASK;
    end else begin
      o_flag <= (o_flag | i_set) & MASK;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      o_enable <= PIF_RST_REG;
    end else if (i_wr_enable) begin
      o_enable <= i_wdata & MASK;
    end
  end

  // Enable bit at the same position as the flag it gates
  assign o_request = |(o_flag & o_enable);
endmodule
`default_nettype wire

//--- verilog/pif_top.sv
// Peripheral interrupt flag block with APB register access
//
// Functional notes
// - A flag bit sets on its condition regardless of its enable bit and the global enable.
// - A flag bit reads 1 while its interrupt is pending and 0 otherwise.
// - Implemented bits of flag registers two and three are read/write and reset to 0.
// - Flags two holds osc fail, comparator b, comparator a, nvm done, bus collision, lcd, gap, capcmp two.
// - Flags three holds capcmp five at 6, four at 5, three at 4, timer six at 3, timer four at 1.
// - Unimplemented flag bits always read as zero.
// - Each enable bit sits at the same position as the flag it gates in the paired register.
// - No peripheral interrupt reaches the core on O_PERIPH_IRQ unless the peripheral enable bit is set; O_IRQ does not need it.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pif_top (
  input wire logic I_CLK,                  // Core clock, 250 MHz
  input wire logic I_RESET_N,              // Async reset, active low
  input wire logic [7:0] I_PADDR,          // APB address
  input wire logic I_PSEL,                 // APB select
  input wire logic I_PENABLE,              // APB enable
  input wire logic I_PWRITE,               // APB direction
  input wire logic [31:0] I_PWDATA,        // APB write data
  output logic [31:0] O_PRDATA,            // APB read data
  output logic O_PREADY,                   // APB ready
  output logic O_PSLVERR,                  // APB error
  input wire logic [7:0] I_FLAGS_ONE_SET,  // Bank one condition pulses
  input wire logic I_OSC_FAIL,             // Oscillator fail condition
  input wire logic I_COMPARATOR_B,         // Comparator b condition
  input wire logic I_COMPARATOR_A,         // Comparator a condition
  input wire logic I_NVM_WRITE_DONE,       // Nvm write done condition
  input wire logic I_BUS_COLLISION,        // Serial bus collision condition
  input wire logic I_LCD_MODULE,           // Lcd module condition
  input wire logic I_CAPCMP_TWO,           // Capture/compare two condition
  input wire logic I_CAPCMP_THREE,         // Capture/compare three condition
  input wire logic I_CAPCMP_FOUR,          // Capture/compare four condition
  input wire logic I_CAPCMP_FIVE,          // Capture/compare five condition
  input wire logic I_TIMER_FOUR_MATCH,     // Timer four period match
  input wire logic I_TIMER_SIX_MATCH,      // Timer six period match
  input wire logic [5:0] I_CORE_FLAGS,     // Core-owned low bits of control reg
  output logic O_PERIPH_IRQ,               // Peripheral request to core
  output logic O_IRQ                       // Bank event interrupt, level
);
  import pif_pkg::*;

  pif_apb_req_s req;
  pif_bank_s set_vec;
  pif_bank_s flags;
  pif_bank_s enables;
  logic [2:0] bank_req;
  logic [2:0] bank_req_d;
  logic [7:0] control;
  logic [7:0] option_control;
  logic [PIF_EVT_W-1:0] evt_status;
  logic [PIF_EVT_W-1:0] evt_enable;
  logic [PIF_EVT_W-1:0] evt_rise;
  logic wr_access;
  logic rd_access;
  logic addr_hit;
  logic [31:0] next_rdata;
  logic [7:0] wbyte;

  assign req = '{paddr: I_PADDR, psel: I_PSEL, penable: I_PENABLE, pwrite: I_PWRITE, pwdata: I_PWDATA};
  assign wbyte = req.pwdata[7:0];
  assign wr_access = req.psel && req.penable && req.pwrite;
  assign rd_access = req.psel && req.penable && !req.pwrite;

  // Zero wait states: every access completes in its first access cycle
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = req.psel && req.penable && !addr_hit;

  always_comb begin
    addr_hit = 1'b1;
    unique case (req.paddr)
      PIF_OFF_CONTROL, PIF_OFF_OPTION, PIF_OFF_ENABLES_ONE, PIF_OFF_ENABLES_TWO,
      PIF_OFF_ENABLES_THREE, PIF_OFF_FLAGS_ONE, PIF_OFF_FLAGS_TWO, PIF_OFF_FLAGS_THREE,
      PIF_OFF_EVT_STATUS, PIF_OFF_EVT_CLEAR, PIF_OFF_EVT_ENABLE: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // Peripheral condition wiring into the documented bit positions
  always_comb begin
    set_vec = '0;
    set_vec.one = I_FLAGS_ONE_SET;
    set_vec.two[PIF_BIT_OSC_FAIL] = I_OSC_FAIL;
    set_vec.two[PIF_BIT_COMP_B] = I_COMPARATOR_B;
    set_vec.two[PIF_BIT_COMP_A] = I_COMPARATOR_A;
    set_vec.two[PIF_BIT_NVM_DONE] = I_NVM_WRITE_DONE;
    set_vec.two[PIF_BIT_BUS_COLL] = I_BUS_COLLISION;
    set_vec.two[PIF_BIT_LCD] = I_LCD_MODULE;
    set_vec.two[PIF_BIT_CAPCMP_TWO] = I_CAPCMP_TWO;
    set_vec.three[PIF_BIT_CAPCMP_FIVE] = I_CAPCMP_FIVE;
    set_vec.three[PIF_BIT_CAPCMP_FOUR] = I_CAPCMP_FOUR;
    set_vec.three[PIF_BIT_CAPCMP_THREE] = I_CAPCMP_THREE;
    set_vec.three[PIF_BIT_TIMER_SIX] = I_TIMER_SIX_MATCH;
    set_vec.three[PIF_BIT_TIMER_FOUR] = I_TIMER_FOUR_MATCH;
  end

  pif_flag_bank #(.MASK(PIF_MASK_ONE)) u_bank_one (
    .I_CLK(I_CLK),
    .I_RESET_N(I_RESET_N),
    .i_set(set_vec.one),
    .i_wr_flag(wr_access && req.paddr == PIF_OFF_FLAGS_ONE),
    .i_wr_enable(wr_access && req.paddr == PIF_OFF_ENABLES_ONE),
    .i_wdata(wbyte),
    .o_flag(flags.one),
    .o_enable(enables.one),
    .o_request(bank_req[0])
  );

  pif_flag_bank #(.MASK(PIF_MASK_TWO)) u_bank_two (
    .I_CLK(I_CLK),
    .I_RESET_N(I_RESET_N),
    .i_set(set_vec.two),
    .i_wr_flag(wr_access && req.paddr == PIF_OFF_FLAGS_TWO),
    .i_wr_enable(wr_access && req.paddr == PIF_OFF_ENABLES_TWO),
    .i_wdata(wbyte),
    .o_flag(flags.two),
    .o_enable(enables.two),
    .o_request(bank_req[1])
  );

  pif_flag_bank #(.MASK(PIF_MASK_THREE)) u_bank_three (
    .I_CLK(I_CLK),
    .I_RESET_N(I_RESET_N),
    .i_set(set_vec.three),
    .i_wr_flag(wr_access && req.paddr == PIF_OFF_FLAGS_THREE),
    .i_wr_enable(wr_access && req.paddr == PIF_OFF_ENABLES_THREE),
    .i_wdata(wbyte),
    .o_flag(flags.three),
    .o_enable(enables.three),
    .o_request(bank_req[2])
  );

  // Only the two enable bits live here; low bits belong to the core
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      control <= PIF_RST_REG;
    end else if (wr_access && req.paddr == PIF_OFF_CONTROL) begin
      control <= {wbyte[PIF_BIT_GLOBAL_EN], wbyte[PIF_BIT_PERIPH_EN], 6'h00};
    end
  end

  // Option register is plain storage for the timer and edge logic elsewhere
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      option_control <= PIF_RST_REG;
    end else if (wr_access && req.paddr == PIF_OFF_OPTION) begin
      option_control <= wbyte;
    end
  end

  // Request requires both the peripheral and global enables
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_PERIPH_IRQ <= 1'b0;
    end else begin
      O_PERIPH_IRQ <= (|bank_req) && control[PIF_BIT_PERIPH_EN] && control[PIF_BIT_GLOBAL_EN];
    end
  end

  // Bank events: rising edge of each bank's enabled-pending term
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      bank_req_d <= PIF_RST_EVT;
    end else begin
      bank_req_d <= bank_req;
    end
  end
  assign evt_rise = bank_req & ~bank_req_d;

  // Set wins over a clear in the same cycle
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      evt_status <= PIF_RST_EVT;
    end else if (wr_access && req.paddr == PIF_OFF_EVT_CLEAR) begin
      evt_status <= (evt_status & ~wbyte[PIF_EVT_W-1:0]) | evt_rise;
    end else begin
      evt_status <= evt_status | evt_rise;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      evt_enable <= PIF_RST_EVT;
    end else if (wr_access && req.paddr == PIF_OFF_EVT_ENABLE) begin
      evt_enable <= wbyte[PIF_EVT_W-1:0];
    end
  end

  assign O_IRQ = |(evt_status & evt_enable);

  // Read mux; unimplemented bits are already zero in the banks
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (req.paddr)
      PIF_OFF_CONTROL: next_rdata[7:0] = {control[7:6], I_CORE_FLAGS};
      PIF_OFF_OPTION: next_rdata[7:0] = option_control;
      PIF_OFF_ENABLES_ONE: next_rdata[7:0] = enables.one;
      PIF_OFF_ENABLES_TWO: next_rdata[7:0] = enables.two;
      PIF_OFF_ENABLES_THREE: next_rdata[7:0] = enables.three;
      PIF_OFF_FLAGS_ONE: next_rdata[7:0] = flags.one;
      PIF_OFF_FLAGS_TWO: next_rdata[7:0] = flags.two;
      PIF_OFF_FLAGS_THREE: next_rdata[7:0] = flags.three;
      PIF_OFF_EVT_STATUS: next_rdata[PIF_EVT_W-1:0] = evt_status;
      PIF_OFF_EVT_ENABLE: next_rdata[PIF_EVT_W-1:0] = evt_enable;
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Read data is combinational from registers so zero-wait reads stay valid
  assign O_PRDATA = rd_access ? next_rdata : 32'h00000000;
endmodule
`default_nettype wire

//--- tb/pif_top_asserts.sv
// Checker of APB answers and flag readback for the interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module pif_top_asserts
  import pif_pkg::*;
(
  input wire logic I_CLK, // Clock
  input wire logic I_RESET_N, // Reset
  input wire logic [7:0] I_PADDR, // Address
  input wire logic I_PSEL, // Select
  input wire logic I_PENABLE, // Enable
  input wire logic I_PWRITE, // Direction
  input wire logic [31:0] I_PWDATA, // Write data
  input wire logic [31:0] O_PRDATA, // Read data
  input wire logic O_PREADY, // Ready
  input wire logic O_PSLVERR, // Error
  input wire logic I_CAPCMP_TWO, // Unit two
  input wire logic I_TIMER_FOUR_MATCH, // Timer four
  input wire logic O_PERIPH_IRQ, // Core request
  input wire logic O_IRQ // Event level
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  logic acc;
  logic rd;
  logic f2;
  logic f3;
  logic ctl_ge;
  logic ctl_pe;
  assign acc = I_PSEL && I_PENABLE && O_PREADY;
  assign rd = acc && !I_PWRITE;
  // Shadow of two flag bits; a set in the same edge beats a write of 0
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      f2 <= 1'b0;
      f3 <= 1'b0;
    end else begin
      f2 <= I_CAPCMP_TWO || ((acc && I_PWRITE && I_PADDR == 8'h18) ? I_PWDATA[0] : f2);
      f3 <= I_TIMER_FOUR_MATCH || ((acc && I_PWRITE && I_PADDR == 8'h1C) ? I_PWDATA[1] : f3);
    end
  end
  // Shadow of the two stored control enables, updated on the same edge as the design
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctl_ge <= 1'b0;
      ctl_pe <= 1'b0;
    end else if (acc && I_PWRITE && I_PADDR == PIF_OFF_CONTROL) begin
      ctl_ge <= I_PWDATA[PIF_BIT_GLOBAL_EN];
      ctl_pe <= I_PWDATA[PIF_BIT_PERIPH_EN];
    end
  end
  sequence s_rd2; rd && I_PADDR == PIF_OFF_FLAGS_TWO; endsequence
  sequence s_rd3; rd && I_PADDR == PIF_OFF_FLAGS_THREE; endsequence
  property p_ready; I_PSEL && I_PENABLE |-> O_PREADY; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_unmapped; acc && I_PADDR > 8'h28 |-> O_PSLVERR && O_PRDATA == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_gap_two; s_rd2 |-> !O_PRDATA[1]; endproperty
  a_gap_two: assert property (p_gap_two) else $error("gap of flags two set");
  property p_gap_three; s_rd3 |-> (O_PRDATA[7:0] & 8'h85) == 8'h00; endproperty
  a_gap_three: assert property (p_gap_three) else $error("gap of flags three set");
  property p_upper; rd |-> O_PRDATA[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_set_two; s_rd2 |-> O_PRDATA[0] == f2; endproperty
  a_set_two: assert property (p_set_two) else $error("unit two flag wrong");
  property p_set_three; s_rd3 |-> O_PRDATA[1] == f3; endproperty
  a_set_three: assert property (p_set_three) else $error("timer four flag wrong");
  property p_reset_quiet; $rose(I_RESET_N) |-> !O_PERIPH_IRQ && !O_IRQ; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("request after reset");
  // Output is registered, so the gate of this cycle decides the next one
  property p_gate; !(ctl_ge && ctl_pe) |=> !O_PERIPH_IRQ; endproperty
  a_gate: assert property (p_gate) else $error("core request without both enables");
endmodule
bind pif_top pif_top_asserts chk_u (.I_CLK, .I_RESET_N, .I_PADDR, .I_PSEL, .I_PENABLE, .I_PWRITE,
  .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR, .I_CAPCMP_TWO, .I_TIMER_FOUR_MATCH, .O_PERIPH_IRQ, .O_IRQ);
`default_nettype wire

//--- tb/pif_periph_model.sv
// Peripheral side model: turns requests into condition pulses one cycle later
`timescale 1ns/1ps
`default_nettype none
module pif_periph_model
  import pif_pkg::*;
(
  input wire logic I_CLK, // Core clock
  input wire logic I_RESET_N, // Reset, active low
  input wire pif_pkg::pif_bank_s i_req, // Requested conditions
  output var pif_pkg::pif_bank_s o_cond // Condition pulses
);
  // Conditions copy the requests one cycle late, so any stickiness must come from the flags
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      o_cond <= '0;
    end else begin
      o_cond <= i_req;
    end
  end
endmodule
`default_nettype wire

//--- tb/pif_top_test.sv
// Bench: APB register access, flag setting and interrupt levels
`timescale 1ns/1ps
`default_nettype none
module pif_top_test;
  import pif_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, pirq, irq;
  logic [7:0] paddr = '0, w = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [5:0] core = '0;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  logic [7:0] masks [7] = '{8'hFF, 8'hFF, 8'hFD, 8'h7A, 8'hFF, 8'hFD, 8'h7A};
  pif_bank_s req = '0, cond;
  int err_total = 0, comparisons = 0, cyc = 0, seed = 32'hd135;
  pif_periph_model peri_u (.I_CLK(clk), .I_RESET_N(rst_n), .i_req(req), .o_cond(cond));
  pif_top dut_u (.I_CLK(clk), .I_RESET_N(rst_n), .I_PADDR(paddr), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_FLAGS_ONE_SET(cond.one), .I_OSC_FAIL(cond.two[7]), .I_COMPARATOR_B(cond.two[6]),
    .I_COMPARATOR_A(cond.two[5]), .I_NVM_WRITE_DONE(cond.two[4]), .I_BUS_COLLISION(cond.two[3]),
    .I_LCD_MODULE(cond.two[2]), .I_CAPCMP_TWO(cond.two[0]), .I_CAPCMP_THREE(cond.three[4]),
    .I_CAPCMP_FOUR(cond.three[5]), .I_CAPCMP_FIVE(cond.three[6]), .I_TIMER_FOUR_MATCH(cond.three[1]),
    .I_TIMER_SIX_MATCH(cond.three[3]), .I_CORE_FLAGS(core), .O_PERIPH_IRQ(pirq), .O_IRQ(irq));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic stop_test();
    $display("comparisons %0d, err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic note(input logic bad, input logic [32:0] got, input logic [32:0] want);
    comparisons++;
    if (bad) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic chk_rd(input logic [32:0] got, input logic [32:0] want);
    note(got !== want, got, want);
  endtask
  // Request output is registered: let two edges pass before looking
  task automatic chk_irq(input logic p, input logic i);
    repeat (2) @(posedge clk);
    note({pirq, irq} !== {p, i}, 33'({pirq, irq}), 33'({p, i}));
  endtask
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic err, input logic [7:0] d);
    exp_q.push_back({err, 24'h0, d});
    xfer(a, 1'b0, 32'h0);
  endtask
  task automatic fire(input pif_bank_s v);
    req <= v;
    @(posedge clk);
    req <= '0;
    repeat (4) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready) begin
      e = exp_q.pop_front();
      chk_rd({pslverr, prdata}, e);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    core = 6'($random(seed));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a <= 8'h28; a += 4) rd(8'(a), 1'b0, a == 0 ? {2'b00, core} : 8'h00);
    rd(8'h2C, 1'b1, 8'h00);
    rd(8'hFC, 1'b1, 8'h00);
    for (int i = 0; i < 14; i++) begin
      w = i < 7 ? 8'hFF : 8'($random(seed));
      xfer(8'(4 + 4 * (i % 7)), 1'b1, {24'hA5A5A5, w});
      rd(8'(4 + 4 * (i % 7)), 1'b0, w & masks[i % 7]);
      xfer(8'(4 + 4 * (i % 7)), 1'b1, 32'h0);
    end
    // Each condition alone, with every enable off
    for (int b = 0; b < 24; b++) begin
      fire(pif_bank_s'(24'h1 << b));
      rd(8'(28 - 4 * (b / 8)), 1'b0, 8'(1 << (b % 8)) & masks[6 - b / 8]);
      chk_irq(1'b0, 1'b0);
      xfer(8'(28 - 4 * (b / 8)), 1'b1, 32'h0);
    end
    xfer(8'h28, 1'b1, 32'h2);
    xfer(8'h18, 1'b1, 32'h0);
    xfer(8'h0C, 1'b1, 32'h1);
    xfer(8'h00, 1'b1, 32'h80);
    fire(pif_bank_s'(24'h000100));
    chk_irq(1'b0, 1'b1);
    xfer(8'h00, 1'b1, 32'hC0);
    chk_irq(1'b1, 1'b1);
    xfer(8'h00, 1'b1, 32'h40);
    chk_irq(1'b0, 1'b1);
    xfer(8'h00, 1'b1, 32'hC0);
    rd(8'h20, 1'b0, 8'h02);
    xfer(8'h24, 1'b1, 32'h2);
    chk_irq(1'b1, 1'b0);
    xfer(8'h28, 1'b1, 32'h0);
    xfer(8'h18, 1'b1, 32'h0);
    chk_irq(1'b0, 1'b0);
    fire(pif_bank_s'(24'h000100));
    chk_irq(1'b1, 1'b0);
    xfer(8'h20, 1'b1, 32'h0);
    rd(8'h20, 1'b0, 8'h02);
    xfer(8'h28, 1'b1, 32'h2);
    chk_irq(1'b1, 1'b1);
    xfer(8'h24, 1'b1, 32'h7);
    chk_irq(1'b1, 1'b0);
    // Events of banks one and three, while bank two stays pending
    xfer(8'h08, 1'b1, 32'h1);
    fire(pif_bank_s'(24'h010000));
    xfer(8'h10, 1'b1, 32'h2);
    fire(pif_bank_s'(24'h000002));
    rd(8'h20, 1'b0, 8'h05);
    xfer(8'h2C, 1'b1, 32'hFF);
    chk_irq(1'b1, 1'b0);
    // Second reset with flags and requests pending
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 8'h14; a <= 8'h20; a += 4) rd(8'(a), 1'b0, 8'h00);
    chk_irq(1'b0, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
